// File: design/slb_top.sv
// Purpose: loopback and single-step control of a bus script engine
// Assumes: engine issues instruction-done pulses; pins sync'd here
// Notes: loopback needs both loopback bits set
// Contract
// [RL1] both loopback bits: loop internally, pins released
// [RL2] engine drives all signals in either role
// [RL3] host drives target signals, reads sampled lines
// [RL4] single-step bit halts after every instruction
// [RL5] enable bit raises interrupt at step halt
// [RL6] software keeps test bits 7:6,0 clear
// [RL7] software clears control bits 3:2; here bit 2 is the start bit and the bench writes it set
// [RL8] test bits 5,2:1 ignored by loopback
// [RL9] block move accepts any memory address
// [RL10] status reads clear pending interrupts
// [RL11] start bit resumes after step halt
// [RL12] pending interrupt blocks further execution
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module slb_top (
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [5:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	input wire logic [7:0] PIN_CTRL_IN,
	input wire logic [7:0] PIN_DATA_IN,
	output logic [7:0] PIN_CTRL_OUT,
	output logic [7:0] PIN_DATA_OUT,
	output logic PIN_OE_N_OUT,
	input wire logic ENG_DONE_IN,
	input wire logic ENG_EVENT_IN,
	output logic ENG_GO_OUT,
	output logic [31:0] BLOCK_ADDR_OUT,
	output logic IRQ_OUT
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] test_two_r, test_two_nxt;
	logic [7:0] dma_control_r, dma_control_nxt;
	logic [7:0] dma_int_en_r, dma_int_en_nxt;
	slb_pkg::slb_bus_t host_out_r, host_out_nxt;
	slb_pkg::slb_bus_t eng_out_r, eng_out_nxt;
	logic [31:0] blk_addr_r, blk_addr_nxt;
	logic [1:0] int_stat_r, int_stat_nxt;
	logic [1:0] int_mask_r, int_mask_nxt;
	logic step_flag_r, step_flag_nxt;
	logic [7:0] rdata_nxt;
	logic [7:0] pin_ctrl_nxt, pin_data_nxt;
	logic oe_n_nxt, irq_nxt, go_nxt;
	slb_pkg::slb_eng_t eng_r, eng_nxt;
	logic [slb_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [15:0] pins_sync;
	logic loop_on;
	slb_pkg::slb_bus_t bus_now;
	logic wr_hit_ctrl, start_req;

	slb_sync #(
		.W(16)
	) u_sync (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.d_in({PIN_CTRL_IN, PIN_DATA_IN}),
		.q_out(pins_sync)
	);

	// ----------------------------------------
	// bus view
	// ----------------------------------------
	always_comb begin
		// only bits 4:3 matter; other test bits left unread
		loop_on = test_two_r[slb_pkg::TST_LOOP_HI] & test_two_r[slb_pkg::TST_LOOP_LO]; // see [RL1] [RL8]
		if (loop_on) begin
			// wired-or of engine and host drivers, as on a real bus
			bus_now.ctrl = eng_out_r.ctrl | host_out_r.ctrl; // see [RL2] [RL3]
			bus_now.data = eng_out_r.data | host_out_r.data;
		end else begin
			bus_now.ctrl = pins_sync[15:8];
			bus_now.data = pins_sync[7:0];
		end
	end

	// ----------------------------------------
	// register writes and interrupts
	// ----------------------------------------
	always_comb begin
		test_two_nxt = test_two_r;
		dma_control_nxt = dma_control_r;
		dma_int_en_nxt = dma_int_en_r;
		host_out_nxt = host_out_r;
		eng_out_nxt = eng_out_r;
		blk_addr_nxt = blk_addr_r;
		int_mask_nxt = int_mask_r;
		int_stat_nxt = int_stat_r;
		step_flag_nxt = step_flag_r;
		wr_hit_ctrl = 1'b0;
		if (WR_IN) begin
			unique case (ADDR_IN)
				slb_pkg::OFS_SCSI_TEST_TWO: test_two_nxt = WDATA_IN;
				slb_pkg::OFS_DMA_CONTROL: begin
					// start bit is self-clearing
					dma_control_nxt = WDATA_IN & ~slb_pkg::START_MASK;
					wr_hit_ctrl = 1'b1;
				end
				slb_pkg::OFS_DMA_INT_ENABLE: dma_int_en_nxt = WDATA_IN;
				slb_pkg::OFS_BUS_CTRL_OUT: host_out_nxt.ctrl = WDATA_IN; // see [RL3]
				slb_pkg::OFS_BUS_DATA_OUT: host_out_nxt.data = WDATA_IN; // see [RL3]
				slb_pkg::OFS_ENGINE_CTRL_OUT: eng_out_nxt.ctrl = WDATA_IN; // see [RL2]
				slb_pkg::OFS_ENGINE_DATA_OUT: eng_out_nxt.data = WDATA_IN; // see [RL2]
				slb_pkg::OFS_INT_STATUS: int_stat_nxt = int_stat_r & ~WDATA_IN[1:0];
				slb_pkg::OFS_INT_MASK: int_mask_nxt = WDATA_IN[1:0];
				// full byte-granular address, no alignment imposed
				slb_pkg::OFS_BLOCK_ADDR0: blk_addr_nxt[7:0] = WDATA_IN; // see [RL9]
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h01: blk_addr_nxt[15:8] = WDATA_IN; // see [RL9]
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h02: blk_addr_nxt[23:16] = WDATA_IN; // see [RL9]
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h03: blk_addr_nxt[31:24] = WDATA_IN; // see [RL9]
				default: ;
			endcase
		end
		if (RD_IN && ADDR_IN == slb_pkg::OFS_DMA_STATUS) begin
			step_flag_nxt = 1'b0; // see [RL10]
			int_stat_nxt = int_stat_nxt & ~(2'b01 << slb_pkg::INT_SSTEP);
		end
		if (RD_IN && ADDR_IN == slb_pkg::OFS_INT_STATUS) begin
			int_stat_nxt = int_stat_nxt & ~(2'b01 << slb_pkg::INT_ENGINE); // see [RL10]
		end
		// hardware sets win over clears
		if (eng_r == slb_pkg::ENG_RUN && cnt_r == '0 && ENG_DONE_IN &&
				dma_control_r[slb_pkg::DCTL_SSTEP] && dma_int_en_r[slb_pkg::INTEN_SSTEP]) begin
			step_flag_nxt = 1'b1; // see [RL5]
			int_stat_nxt[slb_pkg::INT_SSTEP] = 1'b1;
		end
		if (ENG_EVENT_IN) begin
			int_stat_nxt[slb_pkg::INT_ENGINE] = 1'b1;
		end
		irq_nxt = |(int_stat_nxt & int_mask_nxt);
	end

	// ----------------------------------------
	// engine sequencing
	// ----------------------------------------
	always_comb begin
		start_req = wr_hit_ctrl & WDATA_IN[slb_pkg::DCTL_START];
		eng_nxt = eng_r;
		cnt_nxt = cnt_r;
		go_nxt = 1'b0;
		unique case (eng_r)
			slb_pkg::ENG_IDLE,
			slb_pkg::ENG_HALT: begin
				// pending interrupt keeps the engine parked
				if (start_req && !(|int_stat_r) && !step_flag_r) begin // see [RL11] [RL12]
					eng_nxt = slb_pkg::ENG_RUN;
					go_nxt = 1'b1;
					cnt_nxt = slb_pkg::CNT_W'(slb_pkg::INSTR_CYCLES - 1);
				end
			end
			slb_pkg::ENG_RUN: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (ENG_DONE_IN) begin
					if (dma_control_r[slb_pkg::DCTL_SSTEP]) begin
						eng_nxt = slb_pkg::ENG_HALT; // see [RL4]
					end else if (|int_stat_r) begin
						eng_nxt = slb_pkg::ENG_HALT; // see [RL12]
					end else begin
						go_nxt = 1'b1;
						cnt_nxt = slb_pkg::CNT_W'(slb_pkg::INSTR_CYCLES - 1);
					end
				end
			end
			default: eng_nxt = slb_pkg::ENG_IDLE;
		endcase
	end

	// ----------------------------------------
	// read data and pins
	// ----------------------------------------
	always_comb begin
		rdata_nxt = slb_pkg::RST_BYTE;
		if (RD_IN) begin
			unique case (ADDR_IN)
				slb_pkg::OFS_SCSI_TEST_TWO: rdata_nxt = test_two_r;
				slb_pkg::OFS_DMA_CONTROL: rdata_nxt = dma_control_r;
				slb_pkg::OFS_DMA_INT_ENABLE: rdata_nxt = dma_int_en_r;
				slb_pkg::OFS_BUS_CTRL_OUT: rdata_nxt = host_out_r.ctrl;
				slb_pkg::OFS_BUS_DATA_OUT: rdata_nxt = host_out_r.data;
				slb_pkg::OFS_BUS_CTRL_SAMPLE: rdata_nxt = bus_now.ctrl; // see [RL3]
				slb_pkg::OFS_BUS_DATA_SAMPLE: rdata_nxt = bus_now.data; // see [RL3]
				slb_pkg::OFS_DMA_STATUS: rdata_nxt = {4'h0, step_flag_r, 3'h0};
				slb_pkg::OFS_INT_STATUS: rdata_nxt = {6'h00, int_stat_r};
				slb_pkg::OFS_INT_MASK: rdata_nxt = {6'h00, int_mask_r};
				slb_pkg::OFS_ENGINE_CTRL_OUT: rdata_nxt = eng_out_r.ctrl;
				slb_pkg::OFS_ENGINE_DATA_OUT: rdata_nxt = eng_out_r.data;
				slb_pkg::OFS_BLOCK_ADDR0: rdata_nxt = blk_addr_r[7:0];
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h01: rdata_nxt = blk_addr_r[15:8];
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h02: rdata_nxt = blk_addr_r[23:16];
				slb_pkg::OFS_BLOCK_ADDR0 + 6'h03: rdata_nxt = blk_addr_r[31:24];
				default: rdata_nxt = slb_pkg::RST_BYTE;
			endcase
		end
		// in loopback nothing reaches the real bus
		oe_n_nxt = (test_two_nxt[slb_pkg::TST_LOOP_HI] & test_two_nxt[slb_pkg::TST_LOOP_LO]); // see [RL1]
		pin_ctrl_nxt = oe_n_nxt ? 8'h00 : (eng_out_nxt.ctrl | host_out_nxt.ctrl);
		pin_data_nxt = oe_n_nxt ? 8'h00 : (eng_out_nxt.data | host_out_nxt.data);
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			test_two_r <= slb_pkg::RST_BYTE;
			dma_control_r <= slb_pkg::RST_BYTE;
			dma_int_en_r <= slb_pkg::RST_BYTE;
			host_out_r <= '0;
			eng_out_r <= '0;
			blk_addr_r <= 32'h0000_0000;
			int_stat_r <= 2'h0;
			int_mask_r <= 2'h0;
			step_flag_r <= 1'b0;
			eng_r <= slb_pkg::ENG_IDLE;
			cnt_r <= '0;
			RDATA_OUT <= 8'h00;
			PIN_CTRL_OUT <= 8'h00;
			PIN_DATA_OUT <= 8'h00;
			PIN_OE_N_OUT <= 1'b1;
			ENG_GO_OUT <= 1'b0;
			BLOCK_ADDR_OUT <= 32'h0000_0000;
			IRQ_OUT <= 1'b0;
		end else begin
			test_two_r <= test_two_nxt;
			dma_control_r <= dma_control_nxt;
			dma_int_en_r <= dma_int_en_nxt;
			host_out_r <= host_out_nxt;
			eng_out_r <= eng_out_nxt;
			blk_addr_r <= blk_addr_nxt;
			int_stat_r <= int_stat_nxt;
			int_mask_r <= int_mask_nxt;
			step_flag_r <= step_flag_nxt;
			eng_r <= eng_nxt;
			cnt_r <= cnt_nxt;
			RDATA_OUT <= rdata_nxt;
			PIN_CTRL_OUT <= pin_ctrl_nxt;
			PIN_DATA_OUT <= pin_data_nxt;
			PIN_OE_N_OUT <= oe_n_nxt;
			ENG_GO_OUT <= go_nxt;
			BLOCK_ADDR_OUT <= blk_addr_nxt;
			IRQ_OUT <= irq_nxt;
		end
	end
endmodule : slb_top

// File: common/slb_pkg.sv
// Purpose: shared constants and types for the loopback and single-step block
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are local to this block
package slb_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [5:0] OFS_SCSI_TEST_TWO = 6'h00;
	localparam logic [5:0] OFS_DMA_CONTROL = 6'h01;
	localparam logic [5:0] OFS_DMA_INT_ENABLE = 6'h02;
	localparam logic [5:0] OFS_BUS_CTRL_OUT = 6'h03;
	localparam logic [5:0] OFS_BUS_DATA_OUT = 6'h04;
	localparam logic [5:0] OFS_BUS_CTRL_SAMPLE = 6'h05;
	localparam logic [5:0] OFS_BUS_DATA_SAMPLE = 6'h06;
	localparam logic [5:0] OFS_DMA_STATUS = 6'h07;
	localparam logic [5:0] OFS_INT_STATUS = 6'h08;
	localparam logic [5:0] OFS_INT_MASK = 6'h09;
	localparam logic [5:0] OFS_ENGINE_CTRL_OUT = 6'h0A;
	localparam logic [5:0] OFS_ENGINE_DATA_OUT = 6'h0B;
	localparam logic [5:0] OFS_BLOCK_ADDR0 = 6'h0C;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int TST_LOOP_LO = 3;
	localparam int TST_LOOP_HI = 4;
	localparam int DCTL_START = 2;
	localparam int DCTL_SSTEP = 4;
	localparam int INTEN_SSTEP = 3;
	localparam int STAT_SSTEP = 3;
	localparam int INT_SSTEP = 0;
	localparam int INT_ENGINE = 1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] START_MASK = 8'h04;
	localparam int INSTR_CYCLES = 4;
	localparam int CNT_W = 3;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_RUN = 2'b01,
		ENG_HALT = 2'b10
	} slb_eng_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] data;
	} slb_bus_t;
endpackage : slb_pkg

// File: design/slb_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to the clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module slb_sync #(
	parameter int W = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		s1_nxt = d_in;
		q_nxt = s1_r;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_r <= '0;
			q_out <= '0;
		end else begin
			s1_r <= s1_nxt;
			q_out <= q_nxt;
		end
	end
endmodule : slb_sync

// File: testbench/slb_properties.sv
// Purpose: port-level checks for slb_top
// Assumes: one clock, async active-low reset
// Notes: a few control bits are shadowed from the write strobe
`timescale 1ns/1ps
module slb_properties (
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [5:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic [7:0] PIN_CTRL_OUT,
	input wire logic [7:0] PIN_DATA_OUT,
	input wire logic PIN_OE_N_OUT,
	input wire logic ENG_DONE_IN,
	input wire logic ENG_EVENT_IN,
	input wire logic ENG_GO_OUT,
	input wire logic IRQ_OUT
);
	logic loop_r;
	logic step_r;
	logic [1:0] msk_r;
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			loop_r <= 1'b0;
			step_r <= 1'b0;
			msk_r <= 2'h0;
		end else if (WR_IN) begin
			if (ADDR_IN == slb_pkg::OFS_SCSI_TEST_TWO)
				loop_r <= WDATA_IN[slb_pkg::TST_LOOP_HI] & WDATA_IN[slb_pkg::TST_LOOP_LO];
			if (ADDR_IN == slb_pkg::OFS_DMA_CONTROL)
				step_r <= WDATA_IN[slb_pkg::DCTL_SSTEP];
			if (ADDR_IN == slb_pkg::OFS_INT_MASK)
				msk_r <= WDATA_IN[1:0];
		end
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_loop_pins_off: assert property (loop_r && $past(loop_r) |-> PIN_OE_N_OUT)
		else $error("pins driven in loopback");
	a_loop_drive_zero: assert property (loop_r && $past(loop_r) |->
		PIN_CTRL_OUT == 8'h00 && PIN_DATA_OUT == 8'h00)
		else $error("pin levels nonzero in loopback");
	a_go_one_shot: assert property (ENG_GO_OUT |=> !ENG_GO_OUT [*4])
		else $error("go repeated too soon");
	a_go_has_cause: assert property (ENG_GO_OUT |-> $past(ENG_DONE_IN) ||
		$past(WR_IN && ADDR_IN == slb_pkg::OFS_DMA_CONTROL &&
		WDATA_IN[slb_pkg::DCTL_START]))
		else $error("go without start or done");
	a_step_halts: assert property (ENG_DONE_IN && step_r |=> !ENG_GO_OUT [*3])
		else $error("engine ran on in single step");
	a_irq_has_cause: assert property ($rose(IRQ_OUT) |->
		$past(ENG_DONE_IN || ENG_EVENT_IN || WR_IN) ||
		$past(ENG_DONE_IN || ENG_EVENT_IN || WR_IN, 2))
		else $error("irq rose without cause");
	a_irq_masked: assert property (msk_r == 2'h0 && $past(msk_r) == 2'h0 |-> !IRQ_OUT)
		else $error("irq while fully masked");
	a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
		else $error("read data outside read slot");
endmodule : slb_properties

bind slb_top slb_properties slb_properties_i (.*);

// File: testbench/slb_engine_model.sv
// Purpose: script engine stand-in, one instruction per go pulse
// Assumes: go is a one-cycle pulse
// Notes: slow mode stretches the instruction time
`timescale 1ns/1ps
module slb_engine_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic slow_in,
	output logic done_out
);
	logic [3:0] cnt_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 4'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= (cnt_r == 4'h1);
			if (go_in)
				cnt_r <= slow_in ? 4'h9 : 4'h4;
			else if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
		end
	end
endmodule : slb_engine_model

// File: testbench/testbench.sv
// Purpose: self-checking bench for slb_top
// Assumes: 125 MHz clock, engine model on the far side
// Notes: pin inputs held at a fixed pattern
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, evt = 1'b0, slow = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00, rdata, pc, pd;
	logic oe_n, done, go, irq, seen;
	logic [31:0] baddr;
	int miscompares = 0, samples_checked = 0;
	always #4 clk = ~clk;
	slb_top slb_top_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PIN_CTRL_IN(8'h5A), .PIN_DATA_IN(8'hC3),
		.PIN_CTRL_OUT(pc), .PIN_DATA_OUT(pd), .PIN_OE_N_OUT(oe_n), .ENG_DONE_IN(done),
		.ENG_EVENT_IN(evt), .ENG_GO_OUT(go), .BLOCK_ADDR_OUT(baddr), .IRQ_OUT(irq));
	slb_engine_model slb_engine_model_i (.clk_in(clk), .rst_n_in(rst_n), .go_in(go),
		.slow_in(slow), .done_out(done));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr_reg(input logic [5:0] a, input logic [7:0] d);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task rd_reg(input logic [5:0] a, input logic [7:0] e, input string n);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
		@(posedge clk);
	endtask : rd_reg
	// start write to control; go stands only in the cycle after the write edge
	task wr_go(input logic e, input string n);
		wr <= 1'b1; addr <= 6'h01; wdata <= 8'h14;
		@(posedge clk);
		wr <= 1'b0;
		#1 chk(n, {31'h0, e}, {31'h0, go});
		@(posedge clk);
	endtask : wr_go
	// sel 0 watches go, 1 watches irq; go stands one cycle so poll every cycle
	task wait_hi(input int sel, input int lim);
		seen = 1'b0;
		repeat (lim) begin
			#1 if ((sel == 0 ? go : irq) === 1'b1) seen = 1'b1;
			@(posedge clk);
		end
	endtask : wait_hi
	task t_loop;
		rd_reg(6'h06, 8'hC3, "pin data sample");
		wr_reg(6'h00, 8'h3E);
		chk("oe_n loop", 1, oe_n);
		chk("pins loop", 0, {pc, pd});
		wr_reg(6'h03, 8'h20);
		wr_reg(6'h0A, 8'h10);
		wr_reg(6'h04, 8'hA5);
		rd_reg(6'h05, 8'h30, "ctrl sample");
		rd_reg(6'h06, 8'hA5, "data sample");
		wr_reg(6'h00, 8'h08);
		chk("oe_n one bit", 0, oe_n);
		chk("ctrl drive", 8'h30, pc);
	endtask : t_loop
	task t_step;
		slow <= 1'b1;
		wr_reg(6'h09, 8'h01);
		wr_go(1'b1, "go first");
		wait_hi(1, 25);
		chk("irq no enable", 0, seen);
		slow <= 1'b0;
		wr_reg(6'h02, 8'h08);
		wr_go(1'b1, "go step");
		wait_hi(1, 12);
		chk("step irq", 1, seen);
		wr_go(1'b0, "go while pending");
		rd_reg(6'h08, 8'h01, "int status");
		rd_reg(6'h07, 8'h08, "dma status");
		chk("irq cleared", 0, irq);
		wr_go(1'b1, "go resume");
		wait_hi(1, 12);
		rd_reg(6'h07, 8'h08, "dma status again");
	endtask : t_step
	task t_event;
		wr_reg(6'h09, 8'h00);
		evt <= 1'b1;
		@(posedge clk);
		evt <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq masked", 0, irq);
		wr_reg(6'h09, 8'h03);
		wr_reg(6'h08, 8'h00);
		chk("irq event", 1, irq);
		wr_reg(6'h08, 8'h02);
		chk("irq w1c", 0, irq);
	endtask : t_event
	task t_misc;
		wr_reg(6'h0C, 8'h79);
		wr_reg(6'h0D, 8'h56);
		wr_reg(6'h0E, 8'h34);
		wr_reg(6'h0F, 8'h12);
		chk("block address", 32'h12345679, baddr);
		wr_reg(6'h3F, 8'hFF);
		rd_reg(6'h3F, 8'h00, "unmapped");
		rd_reg(6'h01, 8'h10, "dma control");
	endtask : t_misc
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (5) @(posedge clk);
		chk("reset oe_n", 1, oe_n);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_reg(6'h00, 8'h00, "test reg reset");
		t_loop;
		t_step;
		t_misc;
		t_event;
		close_out;
	end
	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		close_out;
	end
endmodule : testbench
